// ===== dv/scd_decoder_bench.sv
// Bench of the command decoder: a table of frames, then reset and short-frame cases.
// Assumes the host model drives the serial pins; timer tables are shrunk.
`timescale 1ns/100ps
`default_nettype none
module scd_decoder_bench
  import scd_pkg::*;
;
  typedef struct packed {
    logic [31:0] f;
    logic        bp;
    logic [19:0] ev;
    logic        wd;
  } scd_row_t;
  localparam int unsigned TD [4] = '{10, 20, 30, 40};
  localparam int unsigned TB [8] = '{5, 6, 7, 8, 9, 10, 11, 12};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        ext  = 1'b0;
  logic        clr  = 1'b1;
  logic        cs_n, sclk, mosi, miso, oe, st, wd, lo, hi, stat, ferr, oe_acc;
  logic [15:0] tdc, obc;
  logic [7:0]  offp, onp, off_acc, on_acc;
  logic [19:0] cnt;
  logic [31:0] xr;
  logic [25:0] xd, xs;
  scd_cfg8_t   cfg8, xc;
  scd_mode_t   mode;
  int          num_errors = 0;
  int          n_compared = 0;
  scd_row_t    rows [20] = '{
    '{32'h87FFFFFE, 1'b0, 20'h00000, 1'b0}, '{32'h82AAAAAA, 1'b0, 20'h00000, 1'b0},
    '{32'h85555554, 1'b0, 20'h00000, 1'b0}, '{32'h88000000, 1'b0, 20'h00000, 1'b0},
    '{32'h80000002, 1'b1, 20'h00001, 1'b0}, '{32'h92AB4A78, 1'b0, 20'h00000, 1'b0},
    '{32'h9AAB4A78, 1'b0, 20'h00000, 1'b0}, '{32'h92A94A78, 1'b0, 20'h00001, 1'b0},
    '{32'hA2AAAAAC, 1'b0, 20'h10000, 1'b1}, '{32'hA2AAAA94, 1'b0, 20'h00000, 1'b0},
    '{32'hA2AAAAC4, 1'b0, 20'h00000, 1'b0}, '{32'hA2AAAAEC, 1'b0, 20'h00000, 1'b1},
    '{32'hA2AAAA9C, 1'b0, 20'h00000, 1'b1}, '{32'hA2AAAA92, 1'b0, 20'h00001, 1'b1},
    '{32'hAAAAAA94, 1'b0, 20'h00000, 1'b1}, '{32'hA2AAAA94, 1'b0, 20'h00000, 1'b0},
    '{32'hBAAAAAAA, 1'b0, 20'h01000, 1'b0}, '{32'hCAAAAAAB, 1'b0, 20'h00100, 1'b0},
    '{32'hDAAAABAA, 1'b0, 20'h00001, 1'b0}, '{32'hDAAAAAAA, 1'b0, 20'h00010, 1'b0}};
  wire logic [4:0] ev = {st, lo, hi, stat, ferr};

  always #2 mclk = ~mclk;

  // Event counters catch a request pulse that is doubled, missing or wrong; diagnostic pulse and OE bits are only ORed
  always @(posedge mclk) begin
    off_acc <= clr ? 8'h00 : off_acc | offp;
    on_acc  <= clr ? 8'h00 : on_acc | onp;
    oe_acc  <= clr ? 1'b0 : oe_acc | oe;
    for (int k = 0; k < 5; k++) cnt[4*k+:4] <= clr ? 4'h0 : cnt[4*k+:4] + 4'(ev[k]);
  end

  scd_host_model u_host (.mclk(mclk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
  scd_decoder #(.TDIAG_CYC(TD), .TBLANK_CYC(TB)) u_dut (
    .mclk(mclk), .rstn(rstn), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .bridge_two_timer_extension(ext), .spi_miso(miso), .spi_miso_oe(oe), .cfg8(cfg8),
    .mode(mode), .tdiag_cycles(tdc), .oc_blank_cycles(obc), .diag_off_pulse(offp),
    .diag_on_pulse(onp), .self_test_request(st), .comm_watchdog_active(wd),
    .integrity_lo_request(lo), .integrity_hi_request(hi), .status_request(stat),
    .frame_error(ferr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic scd_mode_t xmode(input scd_cfg8_t c, input logic x);
    return '{c.bridge_two_enable, c.peakhold_two_enable,
      c.peakhold_two_enable & ~c.peakhold_two_masking_choice,
      c.peakhold_two_enable & c.peakhold_two_masking_choice,
      ~(c.bridge_two_enable & ~x), c.reengagement_strategy | c.bridge_two_enable,
      c.overcurrent_threshold_read_select, c.overcurrent_sense_method,
      c.gate_current_select == 2'h0, c.side_select & c.pmos_select};
  endfunction

  task automatic run(input scd_row_t r, input int n, input int hold);
    logic [31:0] f;
    logic [31:0] rsp;
    logic [15:0] pl;
    logic [25:0] y;
    scd_mode_t   m;
    f = {r.f[31:1], ~^r.f[31:1] ^ r.bp};
    pl = 16'h0000;
    @(posedge mclk) clr <= 1'b1;
    @(posedge mclk) clr <= 1'b0;
    u_host.xfer(f, n, hold, rsp);
    #1;
    if (n == 32) chk(rsp, xr);
    if (!r.ev[0] && n == 32) begin
      if (f[31:28] == CODE_CFG8 && !f[27]) xc = f[26:1];
      if (f[31:28] == CODE_DPULSE && !f[27]) pl = f[16:1];
      if (f[31:28] == CODE_DPULSE && !f[27]) xd = f[26:1];
      if (f[31:28] == CODE_SELFTEST && !f[27]) xs = f[26:1];
      y  = f[31:28] == CODE_CFG8 ? 26'(xc) : f[31:28] == CODE_DPULSE ? xd : xs;
      xr = f[31:28] inside {CODE_CSI_LO, CODE_CSI_HI, CODE_STATUS} ? f
         : {f[31:27], y, ~^{f[31:27], y}};
    end
    chk(32'({oe_acc, oe}), 32'h00000002);
    m = xmode(xc, ext);
    chk(32'(cfg8), 32'(xc));
    chk(32'(mode), 32'(m));
    chk(32'(obc), TB[xc.overcurrent_blanking_time]);
    if (m.tdiag_code_applies) chk(32'(tdc), TD[xc.tdiag_code]);
    chk({16'h0000, off_acc, on_acc}, {16'h0000, pl});
    chk(32'(cnt), 32'(r.ev));
    chk(32'(wd), 32'(r.wd));
  endtask

  task automatic reboot;
    @(posedge mclk) rstn <= 1'b0;
    repeat (15) @(posedge mclk);
    #1;
    chk(32'(cfg8), 32'h00000000);
    chk(32'({mode, wd, oe, offp, onp}), 32'h00000000);
    @(posedge mclk) rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({obc, tdc}, {TB[0][15:0], TD[0][15:0]});
    xc = '0;
    xr = 32'h00000000;
    xd = '0;
    xs = '0;
  endtask

  task automatic results;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    reboot();
    foreach (rows[i]) run(rows[i], 32, 2);
    @(posedge mclk) ext <= 1'b1;
    run(rows[0], 32, 5);
    @(posedge mclk) ext <= 1'b0;
    run('{32'h80000000, 1'b0, 20'h00001, 1'b0}, 31, 5);
    reboot();
    run(rows[16], 32, 2);
    results();
  end
endmodule
`default_nettype wire

// ===== dv/scd_host_model.sv
// Host master model of the command port: mode 0, MSB first.
// Assumes the decoder samples every pin on mclk.
`timescale 1ns/100ps
`default_nettype none
module scd_host_model (
  input  wire logic mclk,
  input  wire logic miso,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Idle data toggles so a stale bit never looks valid
  always @(posedge mclk) if (cs_n) mosi <= ~mosi;
  // Bits n-1 down to 0 of the frame go out, highest first
  task automatic xfer(input logic [31:0] f, input int n, input int hold,
                      output logic [31:0] rsp);
    rsp = 32'h00000000;
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk) mosi <= f[i];
      repeat (hold) @(posedge mclk);
      sclk <= 1'b1;
      repeat (hold) @(posedge mclk);
      rsp = {rsp[30:0], miso};
      sclk <= 1'b0;
    end
    repeat (hold) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ===== verilog/scd_decoder.sv
// Command decoder for output 8 configuration, diagnostic pulses, self-test and fixed frames.
// Assumes SPI pins synchronous to mclk; the timer extension level comes from another decoder.
// Summary of operation
// - Bridge enable bit 26 runs channels 5 to 8 as one H-bridge.
// - Bit 25 picks no-failure or not-diagnosed report in peak-and-hold mode.
// - Bit 24 runs channels 2 and 3 as a peak-and-hold pair.
// - Code 23:22 picks off-state diagnostic timer; ignored for bridge without extension.
// - Bit 21 picks fixed or compensated overcurrent threshold for readback.
// - Bits 20:15 hold the channel 8 overcurrent threshold code.
// - Bits 14:13 pick temperature compensation of the overcurrent threshold.
// - Bit 12 switches battery compensation of overcurrent detection.
// - Bits 11:9 pick overcurrent blanking time, 11.1 to 142.2 us.
// - Bit 8 picks re-engagement strategy; bridges always wait for readout.
// - Bit 7 picks drain-source monitoring or shunt overcurrent sensing.
// - Bit 6 picks 100 uA or 1 mA open-load regulator current.
// - Bits 5:4 pick gate current: external, 20, 5 or 1 mA.
// - Bit 3 picks N-channel or P-channel high-side transistor.
// - Bit 2 picks low or high side; bit 1 enables the output.
// - Bit 0 is odd parity: set when ones in bits 31:1 are even.
// - Bit 27 zero writes and reads back; one only reads back.
// - Pulse frame bits 16:9 request OFF pulses for channels 8 to 1.
// - Pulse frame bits 8:1 request ON pulses for channels 8 to 1.
// - Self-test field 6:5 equal 01 starts logic self-test and self-check.
// - Field 4:3 turns watchdog on with 01, off with 10, else unchanged.
// - Three fixed frames are recognised by their exact pattern.
`timescale 1ns/100ps
`default_nettype none
module scd_decoder
  import scd_pkg::*;
#(
  parameter int unsigned TIMER_W        = 16,
  parameter int unsigned TDIAG_CYC  [4] = TDIAG_CYC_DEF,
  parameter int unsigned TBLANK_CYC [8] = TBLANK_CYC_DEF
)(
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         spi_cs_n,
  input  wire logic         spi_sclk,
  input  wire logic         spi_mosi,
  input  wire logic         bridge_two_timer_extension,
  output logic              spi_miso,
  output logic              spi_miso_oe,
  output scd_cfg8_t         cfg8,
  output scd_mode_t         mode,
  output logic [TIMER_W-1:0] tdiag_cycles,
  output logic [TIMER_W-1:0] oc_blank_cycles,
  output logic [7:0]        diag_off_pulse,
  output logic [7:0]        diag_on_pulse,
  output logic              self_test_request,
  output logic              comm_watchdog_active,
  output logic              integrity_lo_request,
  output logic              integrity_hi_request,
  output logic              status_request,
  output logic              frame_error
);
  if (TDIAG_CYC[3] >= 2**TIMER_W || TBLANK_CYC[7] >= 2**TIMER_W || TIMER_W > 31) begin : g_chk
    $error("scd_decoder: timer counts do not fit TIMER_W");
  end

  logic        rx_done;
  logic [31:0] rx_word;
  logic        rx_len_ok;

  function automatic logic parity_ok(input logic [31:0] w);
    return ^w; // Bit 0 set for even ones above it makes the whole word odd
  endfunction

  function automatic logic [31:0] with_parity(input logic [31:1] w);
    return {w, ~^w};
  endfunction

  logic [31:0] rsp_reg, rsp_next;

  scd_spi_shifter u_shifter (
    .mclk      (mclk),
    .rstn      (rstn),
    .spi_cs_n  (spi_cs_n),
    .spi_sclk  (spi_sclk),
    .spi_mosi  (spi_mosi),
    .tx_word   (rsp_reg),
    .rx_done   (rx_done),
    .rx_word   (rx_word),
    .rx_len_ok (rx_len_ok),
    .miso      (spi_miso),
    .miso_oe   (spi_miso_oe)
  );

  scd_cfg8_t         cfg_reg, cfg_next;
  scd_mode_t         mode_reg, mode_next;
  logic [31:0]       dpulse_reg, dpulse_next;
  logic [31:0]       stest_reg, stest_next;
  logic [7:0]        offp_reg, offp_next;
  logic [7:0]        onp_reg, onp_next;
  logic              logic_self_test_reg, logic_self_test_next;
  logic              wdog_reg, wdog_next;
  logic              csi_lo_reg, csi_lo_next;
  logic              csi_hi_reg, csi_hi_next;
  logic              stat_reg, stat_next;
  logic              err_reg, err_next;
  logic [TIMER_W-1:0] tdiag_reg, tdiag_next;
  logic [TIMER_W-1:0] tblank_reg, tblank_next;

  logic [3:0] code;
  logic       wr;
  logic       good;

  assign code = rx_word[CODE_MSB:CODE_LSB];
  assign wr   = ~rx_word[RW_BIT];

  always_comb begin
    cfg_next    = cfg_reg;
    dpulse_next = dpulse_reg;
    stest_next  = stest_reg;
    rsp_next    = rsp_reg;
    offp_next   = 8'h00;
    onp_next    = 8'h00;
    logic_self_test_next   = 1'b0;
    wdog_next   = wdog_reg;
    csi_lo_next = 1'b0;
    csi_hi_next = 1'b0;
    stat_next   = 1'b0;
    err_next    = 1'b0;
    good        = 1'b0;
    if (rx_done) begin
      // Short or long frames and parity faults are dropped whole
      if (rx_len_ok && parity_ok(rx_word)) begin
        case (code)
          CODE_CFG8: begin
            good = 1'b1;
            if (wr) begin
              cfg_next = rx_word[CFG_MSB:CFG_LSB];
            end
            rsp_next = with_parity({code, rx_word[RW_BIT], cfg_next});
          end
          CODE_DPULSE: begin
            good = (rx_word[DPAT_MSB:DPAT_LSB] == DPULSE_PAT);
            if (good && wr) begin
              offp_next   = rx_word[OFFP_MSB:OFFP_LSB];
              onp_next    = rx_word[ONP_MSB:ONP_LSB];
              dpulse_next = rx_word;
            end
            if (good) begin
              rsp_next = with_parity({code, rx_word[RW_BIT], dpulse_next[26:1]});
            end
          end
          CODE_SELFTEST: begin
            good = (rx_word[STPAT_MSB:STPAT_LSB] == SELFTEST_PAT)
                && (rx_word[STTAIL_MSB:STTAIL_LSB] == SELFTEST_TAIL);
            if (good && wr) begin
              logic_self_test_next  = (rx_word[LOGIC_SELF_TEST_MSB:LOGIC_SELF_TEST_LSB] == LOGIC_SELF_TEST_START);
              stest_next = rx_word;
              if (rx_word[WDOG_MSB:WDOG_LSB] == WDOG_ON) begin
                wdog_next = 1'b1;
              end else if (rx_word[WDOG_MSB:WDOG_LSB] == WDOG_OFF) begin
                wdog_next = 1'b0;
              end
            end
            if (good) begin
              rsp_next = with_parity({code, rx_word[RW_BIT], stest_next[26:1]});
            end
          end
          CODE_CSI_LO: begin
            good        = (rx_word == FRAME_CSI_LO);
            csi_lo_next = good;
          end
          CODE_CSI_HI: begin
            good        = (rx_word == FRAME_CSI_HI);
            csi_hi_next = good;
          end
          CODE_STATUS: begin
            good      = (rx_word == FRAME_STATUS);
            stat_next = good;
          end
          default: good = 1'b0;
        endcase
        if (good && (code == CODE_CSI_LO || code == CODE_CSI_HI || code == CODE_STATUS)) begin
          rsp_next = rx_word;
        end
      end
      err_next = ~good;
    end
  end

  // Mode decode runs from the stored word, so it trails a write by one cycle
  always_comb begin
    mode_next.bridge_two_active             = cfg_reg.bridge_two_enable;
    mode_next.peakhold_two_active           = cfg_reg.peakhold_two_enable;
    mode_next.peakhold_report_no_failure    = cfg_reg.peakhold_two_enable
                                            & ~cfg_reg.peakhold_two_masking_choice;
    mode_next.peakhold_report_not_diagnosed = cfg_reg.peakhold_two_enable
                                            & cfg_reg.peakhold_two_masking_choice;
    mode_next.tdiag_code_applies            = ~(cfg_reg.bridge_two_enable
                                            & ~bridge_two_timer_extension);
    mode_next.reengage_after_readout        = cfg_reg.reengagement_strategy
                                            | cfg_reg.bridge_two_enable;
    mode_next.overcurrent_read_actual       = cfg_reg.overcurrent_threshold_read_select;
    mode_next.overcurrent_shunt_sense       = cfg_reg.overcurrent_sense_method;
    mode_next.gate_current_external         = (cfg_reg.gate_current_select == 2'h0);
    mode_next.high_side_pmos                = cfg_reg.side_select & cfg_reg.pmos_select;
    tdiag_next  = TIMER_W'(TDIAG_CYC[cfg_reg.tdiag_code]);
    tblank_next = TIMER_W'(TBLANK_CYC[cfg_reg.overcurrent_blanking_time]);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg    <= scd_cfg8_t'(CFG8_RST);
      mode_reg   <= '0;
      dpulse_reg <= RSP_RST;
      stest_reg  <= RSP_RST;
      rsp_reg    <= RSP_RST;
      offp_reg   <= 8'h00;
      onp_reg    <= 8'h00;
      logic_self_test_reg   <= 1'b0;
      wdog_reg   <= WDOG_RST;
      csi_lo_reg <= 1'b0;
      csi_hi_reg <= 1'b0;
      stat_reg   <= 1'b0;
      err_reg    <= 1'b0;
      tdiag_reg  <= '0;
      tblank_reg <= '0;
    end else begin
      cfg_reg    <= cfg_next;
      mode_reg   <= mode_next;
      dpulse_reg <= dpulse_next;
      stest_reg  <= stest_next;
      rsp_reg    <= rsp_next;
      offp_reg   <= offp_next;
      onp_reg    <= onp_next;
      logic_self_test_reg   <= logic_self_test_next;
      wdog_reg   <= wdog_next;
      csi_lo_reg <= csi_lo_next;
      csi_hi_reg <= csi_hi_next;
      stat_reg   <= stat_next;
      err_reg    <= err_next;
      tdiag_reg  <= tdiag_next;
      tblank_reg <= tblank_next;
    end
  end

  // Temperature, battery and open-load fields pass straight to the analog stages
  assign cfg8                 = cfg_reg;
  assign mode                 = mode_reg;
  assign tdiag_cycles         = tdiag_reg;
  assign oc_blank_cycles      = tblank_reg;
  assign diag_off_pulse       = offp_reg;
  assign diag_on_pulse        = onp_reg;
  assign self_test_request    = logic_self_test_reg;
  assign comm_watchdog_active = wdog_reg;
  assign integrity_lo_request = csi_lo_reg;
  assign integrity_hi_request = csi_hi_reg;
  assign status_request       = stat_reg;
  assign frame_error          = err_reg;

  AST_BRIDGE_FOLLOWS:
  assert property (@(posedge mclk) disable iff (!rstn)
    rx_done && rx_len_ok && parity_ok(rx_word) && code == CODE_CFG8 && wr
    |-> ##2 mode.bridge_two_active == $past(rx_word[26], 2))
  else $error("bridge mode does not follow bit 26");

  AST_PH_REPORT_EXCL:
  assert property (@(posedge mclk) disable iff (!rstn)
    mode.peakhold_two_active |-> (mode.peakhold_report_no_failure
                                  ^ mode.peakhold_report_not_diagnosed))
  else $error("peak-and-hold report code not exactly one");

  AST_TDIAG_IGNORED:
  assert property (@(posedge mclk) disable iff (!rstn)
    cfg8.bridge_two_enable && !bridge_two_timer_extension |=> !mode.tdiag_code_applies)
  else $error("diagnostic timer code applied in bridge without extension");

  AST_BAD_PARITY_DROPPED:
  assert property (@(posedge mclk) disable iff (!rstn)
    rx_done && !parity_ok(rx_word) |=> frame_error && $stable(cfg8) && diag_on_pulse == 8'h00)
  else $error("frame with bad parity was taken");

  AST_READ_ONLY_KEEPS:
  assert property (@(posedge mclk) disable iff (!rstn)
    rx_done && rx_word[RW_BIT] |=> $stable(cfg8) && $stable(comm_watchdog_active)
                                   && diag_off_pulse == 8'h00)
  else $error("read-only frame changed state");

  AST_OFF_PULSE_ONCE:
  assert property (@(posedge mclk) disable iff (!rstn)
    rx_done && rx_len_ok && parity_ok(rx_word) && code == CODE_DPULSE && wr
    && rx_word[DPAT_MSB:DPAT_LSB] == DPULSE_PAT
    |=> diag_off_pulse == $past(rx_word[OFFP_MSB:OFFP_LSB]) ##1 diag_off_pulse == 8'h00)
  else $error("OFF pulse request not issued once");

  AST_SELFTEST_CAUSE:
  assert property (@(posedge mclk) disable iff (!rstn)
    $rose(self_test_request) |-> $past(rx_done && code == CODE_SELFTEST
                                       && rx_word[LOGIC_SELF_TEST_MSB:LOGIC_SELF_TEST_LSB] == LOGIC_SELF_TEST_START))
  else $error("self-test request without start code");

  AST_WDOG_HOLD:
  assert property (@(posedge mclk) disable iff (!rstn)
    rx_done && (rx_word[WDOG_MSB:WDOG_LSB] == 2'h0 || rx_word[WDOG_MSB:WDOG_LSB] == 2'h3)
    |=> $stable(comm_watchdog_active))
  else $error("watchdog setting changed by a hold code");

  AST_FIXED_EXACT:
  assert property (@(posedge mclk) disable iff (!rstn)
    integrity_hi_request |-> $past(rx_word) == FRAME_CSI_HI && !frame_error)
  else $error("integrity request without exact fixed frame");

  AST_REENGAGE_BRIDGE:
  assert property (@(posedge mclk) disable iff (!rstn)
    $past(cfg8.bridge_two_enable) |-> mode.reengage_after_readout)
  else $error("bridge not forced to readout re-engagement");
endmodule
`default_nettype wire

// ===== verilog/scd_pkg.sv
// Constants, frame layouts and carrier types of the SPI configuration command decoder.
// Assumes a single 250 MHz logic clock; all timing figures convert to cycles of it.
`default_nettype none
package scd_pkg;
  localparam real CLK_PERIOD_NS = 4.0;

  // Frame layout
  localparam int unsigned FRAME_W    = 32;
  localparam int unsigned CODE_MSB   = 31;
  localparam int unsigned CODE_LSB   = 28;
  localparam int unsigned RW_BIT     = 27;
  localparam int unsigned PARITY_BIT = 0;
  localparam int unsigned CFG_MSB    = 26;
  localparam int unsigned CFG_LSB    = 1;
  localparam int unsigned OFFP_MSB   = 16;
  localparam int unsigned OFFP_LSB   = 9;
  localparam int unsigned ONP_MSB    = 8;
  localparam int unsigned ONP_LSB    = 1;
  localparam int unsigned DPAT_MSB   = 26;
  localparam int unsigned DPAT_LSB   = 17;
  localparam int unsigned STPAT_MSB  = 26;
  localparam int unsigned STPAT_LSB  = 7;
  localparam int unsigned LOGIC_SELF_TEST_MSB   = 6;
  localparam int unsigned LOGIC_SELF_TEST_LSB   = 5;
  localparam int unsigned WDOG_MSB   = 4;
  localparam int unsigned WDOG_LSB   = 3;
  localparam int unsigned STTAIL_MSB = 2;
  localparam int unsigned STTAIL_LSB = 1;

  // Command codes and fixed patterns
  localparam logic [3:0]  CODE_CFG8     = 4'h8;
  localparam logic [3:0]  CODE_DPULSE   = 4'h9;
  localparam logic [3:0]  CODE_SELFTEST = 4'hA;
  localparam logic [3:0]  CODE_CSI_LO   = 4'hB;
  localparam logic [3:0]  CODE_CSI_HI   = 4'hC;
  localparam logic [3:0]  CODE_STATUS   = 4'hD;
  localparam logic [9:0]  DPULSE_PAT    = 10'h155;
  localparam logic [19:0] SELFTEST_PAT  = 20'h55555;
  localparam logic [1:0]  SELFTEST_TAIL = 2'h2;
  localparam logic [31:0] FRAME_CSI_LO  = 32'hBAAAAAAA;
  localparam logic [31:0] FRAME_CSI_HI  = 32'hCAAAAAAB;
  localparam logic [31:0] FRAME_STATUS  = 32'hDAAAAAAA;
  localparam logic [1:0]  LOGIC_SELF_TEST_START    = 2'h1;
  localparam logic [1:0]  WDOG_ON       = 2'h1;
  localparam logic [1:0]  WDOG_OFF      = 2'h2;

  // Reset values
  localparam logic [25:0] CFG8_RST      = 26'h0000000;
  localparam logic [31:0] RSP_RST       = 32'h00000000;
  localparam logic        WDOG_RST      = 1'b0;

  // Timing figures in microseconds, converted to least whole cycles
  localparam real TDIAG_US  [4] = '{25.6, 61.2, 105.6, 150.0};
  localparam real TBLANK_US [8] = '{11.1, 15.6, 20.0, 31.1, 42.2, 53.3, 97.8, 142.2};

  function automatic int unsigned us_to_cyc(input real us);
    // Small guard keeps binary rounding of the figure from adding a cycle
    return int'($ceil(us * 1000.0 / CLK_PERIOD_NS - 0.000001));
  endfunction

  localparam int unsigned TDIAG_CYC_DEF [4] = '{us_to_cyc(TDIAG_US[0]), us_to_cyc(TDIAG_US[1]),
                                                 us_to_cyc(TDIAG_US[2]), us_to_cyc(TDIAG_US[3])};
  localparam int unsigned TBLANK_CYC_DEF [8] = '{
    us_to_cyc(TBLANK_US[0]), us_to_cyc(TBLANK_US[1]), us_to_cyc(TBLANK_US[2]),
    us_to_cyc(TBLANK_US[3]), us_to_cyc(TBLANK_US[4]), us_to_cyc(TBLANK_US[5]),
    us_to_cyc(TBLANK_US[6]), us_to_cyc(TBLANK_US[7])};

  // Output 8 configuration word, bits 26 down to 1 of the frame
  typedef struct packed {
    logic       bridge_two_enable;
    logic       peakhold_two_masking_choice;
    logic       peakhold_two_enable;
    logic [1:0] tdiag_code;
    logic       overcurrent_threshold_read_select;
    logic [5:0] overcurrent_threshold_code;
    logic [1:0] overcurrent_temperature_compensation;
    logic       overcurrent_battery_compensation;
    logic [2:0] overcurrent_blanking_time;
    logic       reengagement_strategy;
    logic       overcurrent_sense_method;
    logic       open_load_current_high;
    logic [1:0] gate_current_select;
    logic       pmos_select;
    logic       side_select;
    logic       output_enable;
  } scd_cfg8_t;

  // Operating modes derived from the stored configuration
  typedef struct packed {
    logic bridge_two_active;
    logic peakhold_two_active;
    logic peakhold_report_no_failure;
    logic peakhold_report_not_diagnosed;
    logic tdiag_code_applies;
    logic reengage_after_readout;
    logic overcurrent_read_actual;
    logic overcurrent_shunt_sense;
    logic gate_current_external;
    logic high_side_pmos;
  } scd_mode_t;
endpackage
`default_nettype wire

// ===== verilog/scd_spi_shifter.sv
// Serial shift engine of the command port: MSB first, sample on SCLK rise, shift on fall.
// Assumes the SPI pins are synchronous to mclk and SCLK is well below mclk/2.
`timescale 1ns/100ps
`default_nettype none
module scd_spi_shifter
  import scd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  input  wire logic [31:0] tx_word,
  output logic             rx_done,
  output logic [31:0]      rx_word,
  output logic             rx_len_ok,
  output logic             miso,
  output logic             miso_oe
);
  logic        sclk_reg, sclk_next;
  logic        cs_n_reg, cs_n_next;
  logic [31:0] rx_sh_reg, rx_sh_next;
  logic [31:0] tx_sh_reg, tx_sh_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic        done_reg, done_next;
  logic [31:0] word_reg, word_next;
  logic        len_reg, len_next;
  logic        miso_reg, miso_next;
  logic        oe_reg, oe_next;

  always_comb begin
    sclk_next  = spi_sclk;
    cs_n_next  = spi_cs_n;
    rx_sh_next = rx_sh_reg;
    tx_sh_next = tx_sh_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    word_next  = word_reg;
    len_next   = len_reg;
    miso_next  = miso_reg;
    oe_next    = oe_reg;
    if (!spi_cs_n && cs_n_reg) begin
      // Frame start: first bit must stand before the first rising edge
      tx_sh_next = tx_word;
      miso_next  = tx_word[31];
      cnt_next   = 6'h00;
      oe_next    = 1'b1;
    end else if (spi_cs_n && !cs_n_reg) begin
      done_next = 1'b1;
      word_next = rx_sh_reg;
      len_next  = (cnt_reg == 6'(FRAME_W));
      oe_next   = 1'b0;
    end else if (!spi_cs_n) begin
      if (spi_sclk && !sclk_reg) begin
        rx_sh_next = {rx_sh_reg[30:0], spi_mosi};
        if (cnt_reg != 6'h3F) begin
          cnt_next = cnt_reg + 6'h01;
        end
      end else if (!spi_sclk && sclk_reg) begin
        tx_sh_next = {tx_sh_reg[30:0], 1'b0};
        miso_next  = tx_sh_reg[30];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      rx_sh_reg <= 32'h00000000;
      tx_sh_reg <= 32'h00000000;
      cnt_reg   <= 6'h00;
      done_reg  <= 1'b0;
      word_reg  <= 32'h00000000;
      len_reg   <= 1'b0;
      miso_reg  <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      sclk_reg  <= sclk_next;
      cs_n_reg  <= cs_n_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
      word_reg  <= word_next;
      len_reg   <= len_next;
      miso_reg  <= miso_next;
      oe_reg    <= oe_next;
    end
  end

  assign rx_done   = done_reg;
  assign rx_word   = word_reg;
  assign rx_len_ok = len_reg;
  assign miso      = miso_reg;
  assign miso_oe   = oe_reg;
endmodule
`default_nettype wire
